// file: core/irb_top.sv
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module irb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk, // clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic [WIDTH-1:0] in_data, // word to store
  input wire logic in_valid, // in_data is offered
  output logic in_ready, // room for a word
  output logic [WIDTH-1:0] out_data, // oldest word
  output logic out_valid, // out_data is valid
  input wire logic out_ready // drain side takes the word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fill;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (fill != (PW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data = store[rd_ptr];

  always_ff @(posedge clk)
    if (push)
      store[wr_ptr] <= in_data;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      fill <= fill + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
endmodule // irb_fifo

module irb_top #(
  parameter int SENSOR_COLUMNS = irb_pkg::DEF_SENSOR_COLUMNS,
  parameter int SENSOR_LINES = irb_pkg::DEF_SENSOR_LINES,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk, // 25 MHz clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [3:0] reg_addr, // register index
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after reg_rd
  input wire irb_pkg::irb_pix_t in_pix, // sensor pixel
  input wire logic in_valid, // in_pix offered
  output logic in_ready, // pixel accepted
  output irb_pkg::irb_pix_t out_pix, // reduced pixel toward transport
  output logic out_valid, // out_pix valid
  input wire logic out_ready // transport takes out_pix
);
  localparam int AW = $clog2(SENSOR_COLUMNS * SENSOR_LINES);
  localparam int GW = irb_pkg::GEO_W;
  localparam int PW = irb_pkg::PIX_W;

  typedef enum logic [1:0] {ST_IDLE, ST_CAPTURE, ST_READOUT} irb_state_t;

  // shadow reset is already clamped to the full image, as the idle copy would be
  localparam irb_pkg::irb_cfg_t ACT_RESET = '{
    mirror_columns: irb_pkg::RST_MIRROR, mirror_lines: irb_pkg::RST_MIRROR,
    col_comb: irb_pkg::RST_COMBINE, line_comb: irb_pkg::RST_COMBINE,
    col_sub: irb_pkg::RST_COMBINE, line_sub: irb_pkg::RST_COMBINE,
    roi_w: GW'(SENSOR_COLUMNS), roi_h: GW'(SENSOR_LINES),
    roi_col: irb_pkg::RST_OFFSET, roi_line: irb_pkg::RST_OFFSET, stride: irb_pkg::RST_STRIDE};

  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end

  irb_pkg::irb_cfg_t cfg;
  irb_pkg::irb_cfg_t act;
  logic [GW-1:0] max_cols;
  logic [GW-1:0] max_lines;
  logic [GW-1:0] act_max_cols;
  logic [GW-1:0] act_max_lines;
  irb_state_t state;

  // zero factors behave as one so the divide and counters stay sane
  wire [GW-1:0] cc_eff = (cfg.col_comb == '0) ? GW'(1) : cfg.col_comb;
  wire [GW-1:0] lc_eff = (cfg.line_comb == '0) ? GW'(1) : cfg.line_comb;
  wire [GW-1:0] cs_eff = (cfg.col_sub == '0) ? GW'(1) : cfg.col_sub;
  wire [GW-1:0] ls_eff = (cfg.line_sub == '0) ? GW'(1) : cfg.line_sub;
  wire [GW-1:0] cols_red = (GW'(SENSOR_COLUMNS) / cc_eff) / cs_eff;
  wire [GW-1:0] lines_red = (GW'(SENSOR_LINES) / lc_eff) / ls_eff;
  // depends on combine and subsample only, never on the roi
  wire [GW-1:0] next_max_cols = (cols_red == '0) ? GW'(1) : cols_red;
  wire [GW-1:0] next_max_lines = (lines_red == '0) ? GW'(1) : lines_red;

  // roi held inside the reduced image; offsets are unsigned from the corner
  wire [GW-1:0] col_c = (cfg.roi_col >= max_cols) ? max_cols - GW'(1) : cfg.roi_col;
  wire [GW-1:0] line_c = (cfg.roi_line >= max_lines) ? max_lines - GW'(1) : cfg.roi_line;
  wire [GW-1:0] room_w = max_cols - col_c;
  wire [GW-1:0] room_h = max_lines - line_c;
  wire [GW-1:0] width_c = (cfg.roi_w == '0) ? GW'(1) : (cfg.roi_w > room_w) ? room_w : cfg.roi_w;
  wire [GW-1:0] height_c = (cfg.roi_h == '0) ? GW'(1) : (cfg.roi_h > room_h) ? room_h : cfg.roi_h;

  always_ff @(posedge ref_clk or negedge rst_sync_n)
    if (!rst_sync_n)
      cfg <= irb_pkg::CFG_RESET;
    else if (reg_wr)
      case (reg_addr)
        irb_pkg::REG_CTRL:
        begin
          cfg.mirror_columns <= reg_wdata[irb_pkg::CTRL_MIRROR_COLUMNS];
          cfg.mirror_lines <= reg_wdata[irb_pkg::CTRL_MIRROR_LINES];
        end
        irb_pkg::REG_COL_COMBINE: cfg.col_comb <= reg_wdata;
        irb_pkg::REG_LINE_COMBINE: cfg.line_comb <= reg_wdata;
        irb_pkg::REG_COL_SUBSAMPLE: cfg.col_sub <= reg_wdata;
        irb_pkg::REG_LINE_SUBSAMPLE: cfg.line_sub <= reg_wdata;
        irb_pkg::REG_ROI_WIDTH: cfg.roi_w <= reg_wdata;
        irb_pkg::REG_ROI_HEIGHT: cfg.roi_h <= reg_wdata;
        irb_pkg::REG_ROI_COL_START: cfg.roi_col <= reg_wdata;
        irb_pkg::REG_ROI_LINE_START: cfg.roi_line <= reg_wdata;
        irb_pkg::REG_LINE_STRIDE: cfg.stride <= reg_wdata;
        default: cfg <= cfg;
      endcase

  logic [15:0] next_rdata;
  always_comb
  begin
    case (reg_addr)
      irb_pkg::REG_CTRL: next_rdata = {14'h0000, cfg.mirror_lines, cfg.mirror_columns};
      irb_pkg::REG_COL_COMBINE: next_rdata = cfg.col_comb;
      irb_pkg::REG_LINE_COMBINE: next_rdata = cfg.line_comb;
      irb_pkg::REG_COL_SUBSAMPLE: next_rdata = cfg.col_sub;
      irb_pkg::REG_LINE_SUBSAMPLE: next_rdata = cfg.line_sub;
      irb_pkg::REG_ROI_WIDTH: next_rdata = width_c;
      irb_pkg::REG_ROI_HEIGHT: next_rdata = height_c;
      irb_pkg::REG_ROI_COL_START: next_rdata = col_c;
      irb_pkg::REG_ROI_LINE_START: next_rdata = line_c;
      irb_pkg::REG_LINE_STRIDE: next_rdata = cfg.stride;
      irb_pkg::REG_MAX_COLUMNS: next_rdata = max_cols;
      irb_pkg::REG_MAX_LINES: next_rdata = max_lines;
      irb_pkg::REG_SENSOR_LINES: next_rdata = 16'(SENSOR_LINES);
      irb_pkg::REG_STATUS: next_rdata = {14'h0000, state == ST_READOUT, state == ST_CAPTURE};
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
    if (!rst_sync_n)
    begin
      reg_rdata <= 16'h0000;
      // reset maxima match the reset factors of one, so nothing jumps after release
      max_cols <= GW'(SENSOR_COLUMNS);
      max_lines <= GW'(SENSOR_LINES);
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : 16'h0000;
      max_cols <= next_max_cols;
      max_lines <= next_max_lines;
    end

  // frame shadow follows software only while idle, so a frame never mixes settings
  always_ff @(posedge ref_clk or negedge rst_sync_n)
    if (!rst_sync_n)
    begin
      act <= ACT_RESET;
      act_max_cols <= GW'(SENSOR_COLUMNS);
      act_max_lines <= GW'(SENSOR_LINES);
    end
    else if (state == ST_IDLE)
    begin
      act <= '{mirror_columns: cfg.mirror_columns, mirror_lines: cfg.mirror_lines,
               col_comb: cc_eff, line_comb: lc_eff, col_sub: cs_eff, line_sub: ls_eff,
               roi_w: width_c, roi_h: height_c, roi_col: col_c, roi_line: line_c, stride: cfg.stride};
      act_max_cols <= max_cols;
      act_max_lines <= max_lines;
    end

  // capture: bin, then drop, into the reduced frame store
  logic [PW-1:0] frame [SENSOR_COLUMNS * SENSOR_LINES];
  logic [GW-1:0] hb;
  logic [GW-1:0] hd;
  logic [GW-1:0] vb;
  logic [GW-1:0] vd;
  logic [GW-1:0] rx;
  logic [GW-1:0] ry;
  logic [PW-1:0] hsum;

  assign in_ready = (state != ST_READOUT);
  wire take = in_valid && in_ready;
  wire active = take && ((state == ST_CAPTURE) || in_pix.sof);
  wire [PW:0] hsum_raw = {1'b0, (hb == '0) ? {PW{1'b0}} : hsum} + {1'b0, in_pix.data};
  // sums saturate rather than wrap; a bright bin clips instead of going dark
  wire [PW-1:0] hsum_new = hsum_raw[PW] ? {PW{1'b1}} : hsum_raw[PW-1:0];
  wire col_done = (hb == act.col_comb - GW'(1));
  wire row_done = (vb == act.line_comb - GW'(1));
  wire [31:0] wr_lin = 32'(ry) * 32'(SENSOR_COLUMNS) + 32'(rx);
  wire [AW-1:0] wr_addr = wr_lin[AW-1:0];
  // decimation by plain dropping: only phase zero of each group is kept
  wire frame_we = active && col_done && (hd == '0) && (vd == '0)
                  && (rx < act_max_cols) && (ry < act_max_lines);
  wire [PW:0] vsum_raw = {1'b0, frame[wr_addr]} + {1'b0, hsum_new};
  wire [PW-1:0] vsum = vsum_raw[PW] ? {PW{1'b1}} : vsum_raw[PW-1:0];
  wire [PW-1:0] merged = (vb == '0) ? hsum_new : vsum;

  always_ff @(posedge ref_clk)
    if (frame_we)
      frame[wr_addr] <= merged;

  always_ff @(posedge ref_clk or negedge rst_sync_n)
    if (!rst_sync_n)
    begin
      hb <= '0;
      hd <= '0;
      vb <= '0;
      vd <= '0;
      rx <= '0;
      ry <= '0;
      hsum <= '0;
    end
    else if (active && in_pix.eol)
    begin
      hb <= '0;
      hd <= '0;
      rx <= '0;
      vb <= row_done ? '0 : vb + GW'(1);
      if (row_done)
        vd <= (vd == act.line_sub - GW'(1)) ? '0 : vd + GW'(1);
      if (row_done && vd == '0)
        ry <= ry + GW'(1);
    end
    else if (active)
    begin
      hb <= col_done ? '0 : hb + GW'(1);
      hsum <= hsum_new;
      if (col_done)
        hd <= (hd == act.col_sub - GW'(1)) ? '0 : hd + GW'(1);
      if (col_done && hd == '0)
        rx <= rx + GW'(1);
    end
    else if (state == ST_IDLE)
    begin
      hb <= '0;
      hd <= '0;
      vb <= '0;
      vd <= '0;
      rx <= '0;
      ry <= '0;
    end

  // readout: mirror then crop, pad lines out to the stride
  logic [GW-1:0] ox;
  logic [GW-1:0] oy;
  logic [GW-1:0] lb;
  logic fifo_in_ready;
  irb_pkg::irb_pix_t word;

  wire in_pad = (ox == act.roi_w);
  wire last_real = (ox == act.roi_w - GW'(1));
  wire last_line = (oy == act.roi_h - GW'(1));
  wire [GW-1:0] src_col = act.roi_col + ox;
  wire [GW-1:0] src_line = act.roi_line + oy;
  wire [GW-1:0] rd_col = act.mirror_columns ? act_max_cols - GW'(1) - src_col : src_col;
  wire [GW-1:0] rd_line = act.mirror_lines ? act_max_lines - GW'(1) - src_line : src_line;
  wire [31:0] rd_lin = 32'(rd_line) * 32'(SENSOR_COLUMNS) + 32'(rd_col);
  wire [GW-1:0] next_lb = lb + GW'(irb_pkg::PIX_BYTES);
  // the last line is not padded: the stride only spaces line starts
  wire line_over = (last_real && (last_line || next_lb >= act.stride))
                   || (in_pad && next_lb >= act.stride);
  wire push = (state == ST_READOUT) && fifo_in_ready;

  assign word.data = in_pad ? {PW{1'b0}} : frame[rd_lin[AW-1:0]];
  assign word.sof = (ox == '0) && (oy == '0);
  assign word.eol = last_real;
  assign word.eof = last_real && last_line;
  assign word.pad = in_pad;

  always_ff @(posedge ref_clk or negedge rst_sync_n)
    if (!rst_sync_n)
    begin
      state <= ST_IDLE;
      ox <= '0;
      oy <= '0;
      lb <= '0;
    end
    else
      case (state)
        ST_IDLE:
          if (active && in_pix.eof)
            state <= ST_READOUT;
          else if (active)
            state <= ST_CAPTURE;
        ST_CAPTURE:
          if (active && in_pix.eof)
            state <= ST_READOUT;
        ST_READOUT:
          if (push && line_over)
          begin
            ox <= '0;
            lb <= '0;
            oy <= last_line ? '0 : oy + GW'(1);
            if (last_line)
              state <= ST_IDLE;
          end
          else if (push)
          begin
            ox <= in_pad ? ox : ox + GW'(1);
            lb <= next_lb;
          end
        default: state <= ST_IDLE;
      endcase

  irb_fifo #(
    .WIDTH($bits(irb_pkg::irb_pix_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_out_fifo (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .in_data(word),
    .in_valid(state == ST_READOUT),
    .in_ready(fifo_in_ready),
    .out_data(out_pix),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );

  wire [31:0] max_prod = 32'(max_lines) * 32'(lc_eff) * 32'(ls_eff);

  max_lines_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    $stable(cfg.line_comb) && $stable(cfg.line_sub) |-> (max_lines == 16'h0001)
      || ((max_prod <= 32'(SENSOR_LINES)) && (max_prod + 32'(lc_eff) * 32'(ls_eff) > 32'(SENSOR_LINES))))
    else $error("reduced max lines inconsistent with vertical reduction");
  max_range_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (max_lines != '0) && (max_lines <= GW'(SENSOR_LINES)))
    else $error("reduced max lines out of range");
  roi_indep_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    $stable(cfg.line_comb) && $stable(cfg.line_sub) |=> $stable(max_lines))
    else $error("reduced max lines moved without a vertical reduction change");
  width_eol_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    push && word.eol |-> !word.pad && (ox + GW'(1) == act.roi_w) && (act.roi_col + act.roi_w <= act_max_cols))
    else $error("line ended away from the roi width");
  height_eof_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    push && word.eof |=> (state == ST_IDLE) && (oy == '0))
    else $error("frame end not followed by idle");
  roi_clamp_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (act.roi_line + act.roi_h <= act_max_lines) && (act.roi_h != '0))
    else $error("roi reaches outside the reduced image");
  frame_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    (state != ST_IDLE) && ($past(state) != ST_IDLE) |-> $stable(act))
    else $error("geometry changed inside a frame");
  bin_write_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    frame_we && (act.col_comb == GW'(1)) && (vb == '0) |-> (merged == in_pix.data))
    else $error("single-cell setting altered the stored pixel");
  mirror_first_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    push && (ox == '0) && act.mirror_columns |-> (rd_col == act_max_cols - GW'(1) - act.roi_col))
    else $error("mirrored line does not start at the far column");
  stride_pad_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
    push && word.pad |-> (lb < act.stride) && !last_line)
    else $error("pad word beyond the line stride");
endmodule // irb_top

// file: pkg/irb_pkg.sv
package irb_pkg;
  localparam int PIX_W = 8;
  localparam int PIX_BYTES = 1;
  localparam int GEO_W = 16;
  localparam int DEF_SENSOR_COLUMNS = 64;
  localparam int DEF_SENSOR_LINES = 48;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_COL_COMBINE = 4'h1;
  localparam logic [3:0] REG_LINE_COMBINE = 4'h2;
  localparam logic [3:0] REG_COL_SUBSAMPLE = 4'h3;
  localparam logic [3:0] REG_LINE_SUBSAMPLE = 4'h4;
  localparam logic [3:0] REG_ROI_WIDTH = 4'h5;
  localparam logic [3:0] REG_ROI_HEIGHT = 4'h6;
  localparam logic [3:0] REG_ROI_COL_START = 4'h7;
  localparam logic [3:0] REG_ROI_LINE_START = 4'h8;
  localparam logic [3:0] REG_LINE_STRIDE = 4'h9;
  localparam logic [3:0] REG_MAX_COLUMNS = 4'hA;
  localparam logic [3:0] REG_MAX_LINES = 4'hB;
  localparam logic [3:0] REG_SENSOR_LINES = 4'hC;
  localparam logic [3:0] REG_STATUS = 4'hD;

  localparam int CTRL_MIRROR_COLUMNS = 0;
  localparam int CTRL_MIRROR_LINES = 1;
  localparam int STAT_CAPTURE = 0;
  localparam int STAT_READOUT = 1;

  localparam logic RST_MIRROR = 1'b0;
  localparam logic [15:0] RST_COMBINE = 16'h0001;
  localparam logic [15:0] RST_ROI_SIZE = 16'hFFFF;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [15:0] RST_STRIDE = 16'h0000;

  typedef struct packed {
    logic [PIX_W-1:0] data;
    logic sof;
    logic eol;
    logic eof;
    logic pad;
  } irb_pix_t;

  typedef struct packed {
    logic mirror_columns;
    logic mirror_lines;
    logic [GEO_W-1:0] col_comb;
    logic [GEO_W-1:0] line_comb;
    logic [GEO_W-1:0] col_sub;
    logic [GEO_W-1:0] line_sub;
    logic [GEO_W-1:0] roi_w;
    logic [GEO_W-1:0] roi_h;
    logic [GEO_W-1:0] roi_col;
    logic [GEO_W-1:0] roi_line;
    logic [GEO_W-1:0] stride;
  } irb_cfg_t;

  localparam irb_cfg_t CFG_RESET = '{
    mirror_columns: RST_MIRROR, mirror_lines: RST_MIRROR,
    col_comb: RST_COMBINE, line_comb: RST_COMBINE, col_sub: RST_COMBINE, line_sub: RST_COMBINE,
    roi_w: RST_ROI_SIZE, roi_h: RST_ROI_SIZE, roi_col: RST_OFFSET, roi_line: RST_OFFSET,
    stride: RST_STRIDE};
endpackage

// file: verif/irb_sensor_model.sv
`timescale 1ns/1ps
module irb_sensor_model #(
  parameter int COLS = 8,
  parameter int LINES = 6
) (
  input wire logic ref_clk, // pixel clock
  input wire logic start, // send one frame
  input wire logic slow, // gaps in the feed, transport stalls
  input wire logic in_ready, // stage takes the pixel
  output irb_pkg::irb_pix_t in_pix, // sensor pixel
  output logic in_valid, // pixel offered
  output logic out_ready // transport takes a word
);
  logic [3:0] tick = 4'h0;

  // ten-cycle stalls outlast the four-word buffer, so it fills up
  always @(posedge ref_clk)
  begin
    tick <= tick + 4'h1;
    out_ready <= !slow || tick < 4'h6;
  end

  initial
  begin : feed
    int x;
    int y;
    in_pix = '0;
    in_valid = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      if (start)
      begin
        for (y = 0; y < LINES; y++)
        begin
          for (x = 0; x < COLS; x++)
          begin
            if (slow && x % 2 == 1)
            begin
              in_valid <= 1'b0;
              in_pix.data <= ~in_pix.data;
              @(posedge ref_clk);
            end
            in_valid <= 1'b1;
            in_pix <= '{data: 8'(y * 16 + x), sof: x == 0 && y == 0, eol: x == COLS - 1,
                        eof: x == COLS - 1 && y == LINES - 1, pad: 1'b0};
            @(posedge ref_clk);
            while (in_ready !== 1'b1)
              @(posedge ref_clk);
          end
        end
        in_valid <= 1'b0;
      end
      else
        in_pix.data <= ~in_pix.data; // released data never looks stable
    end
  end
endmodule // irb_sensor_model

// file: verif/test_irb_top.sv
`timescale 1ns/1ps
module test_irb_top;
  localparam int C = 8;
  localparam int L = 6;
  typedef struct {
    logic [1:0] m;
    int bh, bv, dh, dv, w, h, ox, oy, st, mc, ml;
  } irb_row_t;
  // mirrors, factors, roi, stride, then the expected reduced maximum
  irb_row_t rows [7] = '{
    '{2'h0, 1, 1, 1, 1, 8, 6, 0, 0, 0, 8, 6},
    '{2'h0, 2, 1, 1, 1, 4, 6, 0, 0, 0, 4, 6},
    '{2'h0, 1, 2, 2, 1, 4, 3, 0, 0, 0, 4, 3},
    '{2'h1, 1, 1, 1, 3, 3, 2, 1, 0, 4, 8, 2},
    '{2'h2, 3, 1, 1, 2, 5, 0, 1, 5, 0, 2, 3},
    '{2'h3, 0, 1, 1, 0, 2, 2, 3, 2, 7, 8, 6},
    '{2'h3, 8, 6, 1, 2, 9, 9, 0, 0, 3, 1, 1}};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  irb_pkg::irb_pix_t in_pix, out_pix, prev_pix;
  logic in_valid, in_ready, out_valid, out_ready, prev_wait;
  logic start = 1'b0;
  logic slow = 1'b0;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  irb_pkg::irb_pix_t got [$];
  irb_pkg::irb_pix_t exp_q [$];

  irb_top #(.SENSOR_COLUMNS(C), .SENSOR_LINES(L), .FIFO_DEPTH(4)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_pix(in_pix), .in_valid(in_valid), .in_ready(in_ready), .out_pix(out_pix), .out_valid(out_valid),
    .out_ready(out_ready));
  irb_sensor_model #(.COLS(C), .LINES(L)) u_sensor (.ref_clk(ref_clk), .start(start), .slow(slow),
    .in_ready(in_ready), .in_pix(in_pix), .in_valid(in_valid), .out_ready(out_ready));

  always #20 ref_clk = ~ref_clk;

  task automatic print_verdict;
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkpix(input irb_pkg::irb_pix_t g, input irb_pkg::irb_pix_t e);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      print_verdict();
    end
    if (prev_wait)
      chkpix(out_pix, prev_pix);
    if (out_valid === 1'b1 && out_ready)
      got.push_back(out_pix);
    prev_wait <= out_valid === 1'b1 && !out_ready;
    prev_pix <= out_pix;
  end

  task automatic reg_op(input logic wr, input logic rd, input logic [3:0] a, input logic [15:0] d);
    reg_wr <= wr;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    reg_op(1'b0, 1'b1, a, 16'h0000);
    reg_op(1'b0, 1'b0, a, 16'h0000);
    chk16(reg_rdata, e);
  endtask

  task automatic build_exp(input irb_row_t r);
    int bh, bv, dh, dv, rc, rl, ox, oy, w, h, xx, yy, s;
    irb_pkg::irb_pix_t p;
    bh = r.bh == 0 ? 1 : r.bh;
    bv = r.bv == 0 ? 1 : r.bv;
    dh = r.dh == 0 ? 1 : r.dh;
    dv = r.dv == 0 ? 1 : r.dv;
    rc = C / bh / dh < 1 ? 1 : C / bh / dh;
    rl = L / bv / dv < 1 ? 1 : L / bv / dv;
    ox = r.ox < rc ? r.ox : rc - 1;
    oy = r.oy < rl ? r.oy : rl - 1;
    w = r.w == 0 ? 1 : r.w;
    w = w < rc - ox ? w : rc - ox;
    h = r.h == 0 ? 1 : r.h;
    h = h < rl - oy ? h : rl - oy;
    rd_chk(irb_pkg::REG_ROI_WIDTH, 16'(w));
    rd_chk(irb_pkg::REG_ROI_HEIGHT, 16'(h));
    rd_chk(irb_pkg::REG_ROI_COL_START, 16'(ox));
    rd_chk(irb_pkg::REG_ROI_LINE_START, 16'(oy));
    exp_q.delete();
    for (int j = 0; j < h; j++)
    begin
      for (int i = 0; i < w; i++)
      begin
        xx = r.m[0] ? rc - 1 - ox - i : ox + i;
        yy = r.m[1] ? rl - 1 - oy - j : oy + j;
        s = 0;
        for (int a = 0; a < bh; a++)
          for (int b = 0; b < bv; b++)
            s += (yy * dv * bv + b) * 16 + xx * dh * bh + a;
        p = '{data: 8'(s > 255 ? 255 : s), sof: i == 0 && j == 0, eol: i == w - 1,
              eof: i == w - 1 && j == h - 1, pad: 1'b0};
        exp_q.push_back(p);
      end
      if (j < h - 1)
        repeat (r.st - w) exp_q.push_back('{data: 8'h00, sof: 1'b0, eol: 1'b0, eof: 1'b0, pad: 1'b1});
    end
  endtask

  // register indices 0 to 9 follow the row order
  task automatic cfg_frame(input irb_row_t r);
    int v [10];
    v = '{int'(r.m), r.bh, r.bv, r.dh, r.dv, r.w, r.h, r.ox, r.oy, r.st};
    for (int k = 0; k < 10; k++)
      reg_op(1'b1, 1'b0, 4'(k), 16'(v[k]));
    rd_chk(irb_pkg::REG_MAX_COLUMNS, 16'(r.mc));
    rd_chk(irb_pkg::REG_MAX_LINES, 16'(r.ml));
    build_exp(r);
  endtask

  task automatic go_frame(input logic mid);
    int k;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    k = 0;
    if (mid)
    begin
      while (in_ready === 1'b1 && k < 500)
      begin
        @(posedge ref_clk);
        k++;
      end
      reg_op(1'b1, 1'b0, irb_pkg::REG_CTRL, 16'h0003);
      rd_chk(irb_pkg::REG_STATUS, 16'h0002);
    end
    k = 0;
    while (!(got.size() >= exp_q.size() && in_ready === 1'b1 && out_valid === 1'b0) && k < 3000)
    begin
      @(posedge ref_clk);
      k++;
    end
    chk16(16'(got.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
      chkpix(got[i], exp_q[i]);
    got.delete();
  endtask

  initial
  begin : main
    irb_row_t r;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd_chk(irb_pkg::REG_CTRL, 16'h0000);
    rd_chk(irb_pkg::REG_COL_COMBINE, 16'h0001);
    rd_chk(irb_pkg::REG_ROI_WIDTH, 16'(C));
    rd_chk(irb_pkg::REG_LINE_STRIDE, 16'h0000);
    reg_op(1'b1, 1'b0, irb_pkg::REG_MAX_LINES, 16'h0002);
    reg_op(1'b1, 1'b0, irb_pkg::REG_SENSOR_LINES, 16'h0002);
    rd_chk(irb_pkg::REG_MAX_LINES, 16'(L));
    rd_chk(irb_pkg::REG_SENSOR_LINES, 16'(L));
    rd_chk(4'hE, 16'h0000);
    rd_chk(irb_pkg::REG_STATUS, 16'h0000);
    foreach (rows[k])
    begin
      slow <= 1'(k % 2);
      cfg_frame(rows[k]);
      go_frame(1'b0);
    end
    // a change during readout must wait for the next frame
    cfg_frame(rows[0]);
    go_frame(1'b1);
    r = rows[0];
    r.m = 2'h3;
    rd_chk(irb_pkg::REG_CTRL, 16'h0003);
    build_exp(r);
    go_frame(1'b0);
    print_verdict();
  end
endmodule // test_irb_top
